// ### interrupt_accept_timing_guard.sv
// Interrupt acceptance guard: request flags, enables, masking and acceptance points toward the CPU core
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "irq_guard_consts.svh"

module interrupt_accept_timing_guard (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [15:0] external_request_pins_n,
   input wire logic [15:0] keyboard_inputs_n,
   input wire logic [15:0] wakeup_inputs_n,
   input wire logic nmi_req,
   input wire irq_guard_pkg::cpu_status_t cpu_status,
   output irq_guard_pkg::cpu_accept_t cpu_accept
);
   import irq_guard_pkg::*;

   localparam int NS = `NUM_SOURCES;
   localparam int NE = `NUM_EXT_SOURCES;

   logic waitrequest_r;
   logic [31:0] readdata_r;
   cpu_accept_t accept_r;
   logic [NS-1:0] enable_r;
   logic [NS-1:0] en_clr_pend_r;
   logic [NS-1:0] level_r;
   logic [1:0] control_r;
   logic mask_i_r;
   logic mask_ui_r;
   logic nmi_pend_r;
   logic [4:0] last_vec_r;
   instr_class_t cur_class_r;

   logic req_first;
   logic req_done;
   logic wr_done;
   logic rd_first_status;
   logic [31:0] wmask;
   logic [NS-1:0] flags;
   logic [NS-1:0] wr_zero;
   logic instr_end;
   logic kw_level_n;
   logic settle_valid;
   logic settle_i;
   logic settle_ui;
   logic accept_point;
   logic ctrl_mode;
   logic [NS-1:0] pending;
   logic [NS-1:0] eligible;
   logic found;
   logic [4:0] pick;
   logic take_nmi;
   logic take_src;

   assign ctrl_mode = control_r[`CTRL_MODE_BIT];
   assign instr_end = cpu_status.instr_end;

   // Avalon slave: one wait cycle, then completion
   assign req_first = (avs_read | avs_write) & waitrequest_r;
   assign req_done = (avs_read | avs_write) & ~waitrequest_r;
   assign wr_done = avs_write & ~waitrequest_r;
   assign rd_first_status = avs_read & waitrequest_r & (avs_address == `OFS_STATUS);
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                   {8{avs_byteenable[0]}}};
   assign wr_zero = (wr_done && avs_address == `OFS_STATUS) ? (wmask[NS-1:0] & ~avs_writedata[NS-1:0])
                                                           : {NS{1'b0}};

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         waitrequest_r <= 1'b1;
      end else begin
         waitrequest_r <= ~req_first;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         readdata_r <= 32'h00000000;
      end else if (req_first && avs_read) begin
         unique case (avs_address)
            `OFS_STATUS: readdata_r <= {{(32-NS){1'b0}}, flags};
            `OFS_ENABLE: readdata_r <= {{(32-NS){1'b0}}, enable_r};
            `OFS_LEVEL: readdata_r <= {{(32-NS){1'b0}}, level_r};
            `OFS_CONTROL: readdata_r <= {30'h00000000, control_r};
            `OFS_STATE: readdata_r <= {15'h0000, nmi_pend_r, 3'h0, last_vec_r, 6'h00, mask_ui_r, mask_i_r};
            default: readdata_r <= 32'h00000000;
         endcase
      end
   end

   assign avs_waitrequest = waitrequest_r;
   assign avs_readdata = readdata_r;

   // Keyboard and wake-up inputs reach the edge detector only in extended vector mode.
   // Raising the select bit while any of them is low looks like a falling edge,
   // so software must switch modes with those pins high.
   assign kw_level_n = ~control_r[`CTRL_VMS_BIT] | (&keyboard_inputs_n & &wakeup_inputs_n);

   // One flag cell per source; the last cell watches the keyboard and wake-up group.
   // All cells share the status read strobe, so a read arms every set flag at once.
   // Clears stay queued in each cell until the running instruction ends.
   for (genvar g = 0; g < NS; g++) begin : g_flag
      request_flag_cell u_cell (
         .clk_sys(clk_sys),
         .srst(srst),
         .level_n(g < NE ? external_request_pins_n[g % NE] : kw_level_n),
         .status_read(rd_first_status),
         .write_zero(wr_zero[g]),
         .apply(instr_end),
         .flag(flags[g])
      );
   end

   // Enable register: setting acts at once, clearing waits for the instruction end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         en_clr_pend_r <= {NS{1'b0}};
      end else if (wr_done && avs_address == `OFS_ENABLE) begin
         en_clr_pend_r <= (en_clr_pend_r | (wmask[NS-1:0] & ~avs_writedata[NS-1:0] & enable_r))
                          & ~(wmask[NS-1:0] & avs_writedata[NS-1:0]);
      end else if (instr_end) begin
         en_clr_pend_r <= {NS{1'b0}};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         enable_r <= `RST_ENABLE;
      end else if (wr_done && avs_address == `OFS_ENABLE) begin
         enable_r <= enable_r | (wmask[NS-1:0] & avs_writedata[NS-1:0]);
      end else if (instr_end) begin
         enable_r <= enable_r & ~en_clr_pend_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         level_r <= `RST_LEVEL;
      end else if (wr_done && avs_address == `OFS_LEVEL) begin
         level_r <= (level_r & ~wmask[NS-1:0]) | (avs_writedata[NS-1:0] & wmask[NS-1:0]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         control_r <= `RST_CONTROL;
      end else if (wr_done && avs_address == `OFS_CONTROL && avs_byteenable[0]) begin
         control_r <= avs_writedata[1:0];
      end
   end

   // Class of the instruction in flight
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cur_class_r <= INSTR_OTHER;
      end else if (cpu_status.instr_start) begin
         cur_class_r <= cpu_status.instr_class;
      end
   end

   mask_settle_delay #(
      .DEPTH(`MASK_SETTLE_STATES)
   ) u_settle (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(instr_end && cur_class_r == INSTR_COND && cpu_status.ccr_write),
      .in_i(cpu_status.ccr_i),
      .in_ui(cpu_status.ccr_ui),
      .out_valid(settle_valid),
      .out_i(settle_i),
      .out_ui(settle_ui)
   );

   // Acceptance points: ends of instructions other than INSTR_COND, and transfer breaks of the word-count move
   always_comb begin
      accept_point = 1'b0;
      if (instr_end) begin
         accept_point = (cur_class_r != INSTR_COND);
      end else if (cpu_status.xfer_break) begin
         accept_point = (cur_class_r == INSTR_MOVE_WORD);
      end
   end

   // Pending uses the enables in force now, so a clear still in flight keeps its source alive
   assign pending = flags & enable_r;

   always_comb begin
      eligible = {NS{1'b0}};
      for (int k = 0; k < NS; k++) begin
         if (ctrl_mode) begin
            eligible[k] = pending[k] & (level_r[k] ? (~mask_i_r | ~mask_ui_r) : ~mask_i_r);
         end else begin
            eligible[k] = pending[k] & ~mask_i_r;
         end
      end
   end

   // Level-1 sources first, then level 0; lower index wins within a level
   always_comb begin
      found = 1'b0;
      pick = 5'h00;
      for (int k = NS - 1; k >= 0; k--) begin
         if (eligible[k] && !level_r[k]) begin
            found = 1'b1;
            pick = 5'(k);
         end
      end
      for (int k = NS - 1; k >= 0; k--) begin
         if (eligible[k] && level_r[k]) begin
            found = 1'b1;
            pick = 5'(k);
         end
      end
   end

   // NMI ignores both mask bits but still waits for an acceptance point.
   // A source is taken only when no NMI is due at the same point.
   assign take_nmi = accept_point & (nmi_pend_r | nmi_req);
   assign take_src = accept_point & ~take_nmi & found;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         nmi_pend_r <= 1'b0;
      end else if (take_nmi) begin
         nmi_pend_r <= 1'b0;
      end else if (nmi_req) begin
         nmi_pend_r <= 1'b1;
      end
   end

   // Acceptance masks further requests; a settled mask write applies otherwise.
   // A mask write that settles in the same cycle as an acceptance is dropped;
   // one still in the delay line applies later and can unmask the handler.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mask_i_r <= `RST_MASK_I;
         mask_ui_r <= `RST_MASK_UI;
      end else if (take_nmi || take_src) begin
         mask_i_r <= 1'b1;
         mask_ui_r <= ctrl_mode | mask_ui_r;
      end else if (settle_valid) begin
         mask_i_r <= settle_i;
         mask_ui_r <= settle_ui;
      end
   end

   // Answer to the core, one cycle after the acceptance point.
   // Vector and pushed address are refreshed every cycle and are only
   // meaningful in the cycle that carries the accept pulse.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         accept_r <= '0;
      end else begin
         accept_r.accept <= take_nmi | take_src;
         accept_r.nmi <= take_nmi;
         accept_r.vector <= take_nmi ? `NMI_VECTOR : pick;
         accept_r.pushed_pc <= cpu_status.next_pc;
      end
   end

   // Last vector taken, kept for the state register.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         last_vec_r <= 5'h00;
      end else if (take_nmi) begin
         last_vec_r <= `NMI_VECTOR;
      end else if (take_src) begin
         last_vec_r <= pick;
      end
   end

   assign cpu_accept = accept_r;
endmodule
`default_nettype wire

// ### irq_guard_consts.svh
// Offsets, field positions, reset values and timing counts of the acceptance guard
`ifndef IRQ_GUARD_CONSTS_SVH
`define IRQ_GUARD_CONSTS_SVH

`define NUM_EXT_SOURCES 16
`define NUM_SOURCES 17
`define OFS_STATUS 8'h00
`define OFS_ENABLE 8'h04
`define OFS_LEVEL 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_STATE 8'h10
`define CTRL_MODE_BIT 0
`define CTRL_VMS_BIT 1
`define STATE_I_BIT 0
`define STATE_UI_BIT 1
`define STATE_VEC_LSB 8
`define STATE_NMI_PEND_BIT 16
`define RST_ENABLE 17'h00000
`define RST_LEVEL 17'h00000
`define RST_CONTROL 2'h0
`define RST_MASK_I 1'b1
`define RST_MASK_UI 1'b0
`define KW_VECTOR 5'h10
`define NMI_VECTOR 5'h1F
`define MASK_SETTLE_STATES 2

`endif

// ### irq_guard_pkg.sv
// Types shared by the acceptance guard and its CPU core partner
package irq_guard_pkg;

   typedef enum logic [1:0] {
      INSTR_OTHER = 2'b00,
      INSTR_COND = 2'b01,
      INSTR_MOVE_BYTE = 2'b10,
      INSTR_MOVE_WORD = 2'b11
   } instr_class_t;

   typedef struct packed {
      logic instr_start;
      instr_class_t instr_class;
      logic instr_end;
      logic xfer_break;
      logic ccr_write;
      logic ccr_i;
      logic ccr_ui;
      logic [31:0] next_pc;
   } cpu_status_t;

   typedef struct packed {
      logic accept;
      logic nmi;
      logic [4:0] vector;
      logic [31:0] pushed_pc;
   } cpu_accept_t;

endpackage

// ### request_flag_cell.sv
// One edge-detected request flag with read-then-write-zero clearing applied at instruction end
`timescale 1ns/1ns
`default_nettype none
module request_flag_cell (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic level_n,
   input wire logic status_read,
   input wire logic write_zero,
   input wire logic apply,
   output logic flag
);
   logic prev_r;
   logic flag_r;
   logic seen_r;
   logic clear_pend_r;
   logic fall;

   assign fall = prev_r & ~level_n;
   assign flag = flag_r;

   // Prev resets high so a pin already low at release raises the flag
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= level_n;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         seen_r <= 1'b0;
      end else if (status_read) begin
         seen_r <= flag_r;
      end else if (write_zero) begin
         seen_r <= 1'b0;
      end
   end

   // Clear waits for instruction end; a new edge cancels it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clear_pend_r <= 1'b0;
      end else if (fall) begin
         clear_pend_r <= 1'b0;
      end else if (write_zero && seen_r) begin
         clear_pend_r <= 1'b1;
      end else if (apply) begin
         clear_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flag_r <= 1'b0;
      end else if (fall) begin
         flag_r <= 1'b1;
      end else if (apply && clear_pend_r) begin
         flag_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### mask_settle_delay.sv
// Delay line that lets a new mask value settle a fixed number of states
`timescale 1ns/1ns
`default_nettype none
`include "irq_guard_consts.svh"
module mask_settle_delay #(
   parameter int DEPTH = `MASK_SETTLE_STATES
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   input wire logic in_i,
   input wire logic in_ui,
   output logic out_valid,
   output logic out_i,
   output logic out_ui
);
   logic [2:0] stage_r [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int k = 0; k < DEPTH; k++) begin
            stage_r[k] <= 3'h0;
         end
      end else begin
         stage_r[0] <= {in_valid, in_i, in_ui};
         for (int k = 1; k < DEPTH; k++) begin
            stage_r[k] <= stage_r[k-1];
         end
      end
   end

   assign out_valid = stage_r[DEPTH-1][2];
   assign out_i = stage_r[DEPTH-1][1];
   assign out_ui = stage_r[DEPTH-1][0];
endmodule
`default_nettype wire

// ### guard_assertions.sv
// Port-level checker for the interrupt acceptance guard
`timescale 1ns/1ns
`default_nettype none
`include "irq_guard_consts.svh"
module guard_assertions (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire irq_guard_pkg::cpu_status_t cpu_status,
   input wire irq_guard_pkg::cpu_accept_t cpu_accept
);
   import irq_guard_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest late");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest held low");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 8'h20 |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_cond_blocks_all: assert property (cpu_status.instr_end && cpu_status.instr_class == INSTR_COND
      |=> !cpu_accept.accept) else $error("accept after condition write");
   a_byte_move_hold: assert property (cpu_status.xfer_break && cpu_status.instr_class == INSTR_MOVE_BYTE
      |=> !cpu_accept.accept) else $error("accept inside byte move");
   a_accept_point: assert property (cpu_accept.accept |-> $past(cpu_status.instr_end || cpu_status.xfer_break))
      else $error("accept without point");
   a_pushed_pc: assert property (cpu_accept.accept |-> cpu_accept.pushed_pc == $past(cpu_status.next_pc))
      else $error("wrong pushed address");
   a_nmi_vector: assert property (cpu_accept.accept && cpu_accept.nmi |-> cpu_accept.vector == `NMI_VECTOR)
      else $error("wrong nmi vector");
   a_accept_pulse: assert property (cpu_accept.accept |=> !cpu_accept.accept)
      else $error("accept too long");
   c_nmi: cover property (cpu_accept.accept && cpu_accept.nmi);
   c_src: cover property (cpu_accept.accept && !cpu_accept.nmi);
   c_word: cover property (cpu_status.xfer_break ##1 cpu_accept.accept);
endmodule
bind interrupt_accept_timing_guard guard_assertions guard_assertions_i (.clk_sys, .srst, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cpu_status, .cpu_accept);
`default_nettype wire

// ### cpu_model.sv
// Behavioural CPU core that runs instructions and takes exceptions from the guard
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
   input wire logic clk_sys,
   input wire irq_guard_pkg::cpu_accept_t cpu_accept,
   output var irq_guard_pkg::cpu_status_t cpu_status
);
   import irq_guard_pkg::*;
   int n_acc = 0;
   int mid_acc;
   int rem;
   cpu_accept_t last;
   initial cpu_status = '0;
   always @(posedge clk_sys) begin
      if (cpu_accept.accept === 1'b1) begin
         n_acc <= n_acc + 1;
         last <= cpu_accept;
      end
   end
   // Fields: start, class, end and break, write/I/UI; unsampled fields are inverted
   task automatic drive(input logic st, input instr_class_t c, input logic [1:0] eb, input logic [2:0] w,
      input logic [31:0] pc);
      @(posedge clk_sys);
      cpu_status <= {st, c, eb, w, pc};
   endtask
   // Transfers put a break every third cycle and look for acceptance after each
   task automatic exec(input instr_class_t c, input int n, input logic [2:0] w, input logic [31:0] pc);
      mid_acc = 0;
      rem = n;
      drive(1'b1, c, 2'b00, w, pc);
      while (rem > 0) begin
         drive(1'b0, c, 2'b01, w, pc);
         drive(1'b0, c, 2'b00, ~w, ~pc);
         @(posedge clk_sys);
         rem = rem - 1;
         if (cpu_accept.accept === 1'b1) begin
            mid_acc = mid_acc + 1;
            if (c == INSTR_MOVE_WORD) break;
         end
      end
      if (mid_acc == 0 || c != INSTR_MOVE_WORD) drive(1'b0, c, 2'b10, w, pc);
      drive(1'b0, c, 2'b00, ~w, ~pc);
      repeat (2) @(posedge clk_sys);
   endtask
   // Mask write, gap idle cycles, then a short instruction
   task automatic settle(input logic [2:0] w, input int gap, input logic [31:0] pc);
      drive(1'b1, INSTR_COND, 2'b00, w, ~pc);
      drive(1'b0, INSTR_COND, 2'b10, w, ~pc);
      repeat (gap) drive(1'b0, INSTR_COND, 2'b00, ~w, ~pc);
      exec(INSTR_OTHER, 0, 3'b000, pc);
   endtask
endmodule
`default_nettype wire

// ### interrupt_accept_timing_guard_tb.sv
// Self-checking bench for the interrupt acceptance guard
`timescale 1ns/1ns
`default_nettype none
`include "irq_guard_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module interrupt_accept_timing_guard_tb;
   import irq_guard_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic avs_waitrequest;
   logic [15:0] pins_n = 16'hFFDF;
   logic [15:0] kbd_n = 16'hFFFF;
   logic nmi_req = 1'b0;
   cpu_status_t cpu_status;
   cpu_accept_t cpu_accept;
   int err_count = 0;
   int n_checks = 0;
   int base;
   interrupt_accept_timing_guard interrupt_accept_timing_guard_i (.clk_sys, .srst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .external_request_pins_n(pins_n), .keyboard_inputs_n(kbd_n), .wakeup_inputs_n(16'hFFFF), .nmi_req,
      .cpu_status, .cpu_accept);
   cpu_model cpu (.clk_sys, .cpu_accept, .cpu_status);
   always #20 clk_sys = ~clk_sys;
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && t < 20) begin
         @(posedge clk_sys);
         t++;
      end
      if (avs_waitrequest !== 1'b0) begin
         err_count++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic op(input int n, input logic [31:0] pc);
      cpu.exec(INSTR_OTHER, n, 3'b000, pc);
   endtask
   task automatic nmi_pulse;
      nmi_req <= 1'b1;
      @(posedge clk_sys);
      nmi_req <= 1'b0;
   endtask
   task automatic t_reset_flags;
      bus(0, `OFS_STATE, 0);
      `CHK("mask", 32'h1, rd & 32'h3)
      pins_n <= 16'hFFFF;
      bus(1, `OFS_ENABLE, 32'h20);
      bus(1, `OFS_STATUS, 32'h0);
      op(0, 32'h100);
      bus(0, `OFS_STATUS, 0);
      `CHK("flag kept", 32'h20, rd)
      bus(1, `OFS_STATUS, 32'h0);
      op(0, 32'h104);
      bus(0, `OFS_STATUS, 0);
      `CHK("flag cleared", 32'h0, rd)
      `CHK("masked clear", 0, cpu.n_acc)
      bus(0, 8'h20, 0);
      `CHK("unmapped", 32'h0, rd)
   endtask
   task automatic t_conflict;
      cpu.exec(INSTR_COND, 0, 3'b100, 32'h0);
      bus(1, `OFS_ENABLE, 32'h8);
      bus(1, `OFS_ENABLE, 32'h0);
      fork
         begin
            repeat (2) @(posedge clk_sys);
            pins_n <= 16'hFFF7;
         end
      join_none
      op(1, 32'h200);
      `CHK("late request", 5'h03, cpu.last.vector)
      cpu.exec(INSTR_COND, 0, 3'b100, 32'h0);
      op(0, 32'h204);
      `CHK("disable applied", 1, cpu.n_acc)
      pins_n <= 16'hFFF5;
      bus(1, `OFS_ENABLE, 32'hA);
      bus(0, `OFS_STATUS, 0);
      bus(1, `OFS_STATUS, 32'h0);
      op(0, 32'h208);
      `CHK("priority", 5'h01, cpu.last.vector)
      cpu.exec(INSTR_COND, 0, 3'b100, 32'h0);
      op(0, 32'h20C);
      `CHK("dropped", 2, cpu.n_acc)
   endtask
   task automatic t_mask_settle;
      cpu.exec(INSTR_COND, 0, 3'b110, 32'h0);
      pins_n <= 16'hFFFF;
      bus(1, `OFS_ENABLE, 32'h8);
      pins_n <= 16'hFFF7;
      base = cpu.n_acc;
      cpu.settle(3'b100, 0, 32'h300);
      `CHK("unsettled", base, cpu.n_acc)
      op(0, 32'h304);
      cpu.settle(3'b100, 1, 32'h308);
      `CHK("settled", base + 2, cpu.n_acc)
      nmi_pulse;
      cpu.exec(INSTR_COND, 0, 3'b011, 32'h0);
      `CHK("cond blocks", base + 2, cpu.n_acc)
      op(0, 32'h30C);
      `CHK("nmi", `NMI_VECTOR, cpu.last.vector)
   endtask
   task automatic t_moves;
      base = cpu.n_acc;
      nmi_pulse;
      cpu.exec(INSTR_MOVE_BYTE, 3, 3'b000, 32'h400);
      `CHK("byte breaks", 0, cpu.mid_acc)
      `CHK("byte end", base + 1, cpu.n_acc)
      nmi_pulse;
      cpu.exec(INSTR_MOVE_WORD, 3, 3'b000, 32'h500);
      `CHK("word break", 2, cpu.rem)
      `CHK("pushed", 32'h500, cpu.last.pushed_pc)
      while (cpu.rem != 0) begin
         cpu.exec(INSTR_MOVE_WORD, cpu.rem, 3'b000, 32'h500);
      end
   endtask
   task automatic t_modes;
      kbd_n <= 16'hFFFE;
      bus(1, `OFS_CONTROL, 32'h2);
      bus(0, `OFS_STATUS, 0);
      `CHK("mode switch edge", 1'b1, rd[16])
      kbd_n <= 16'hFFFF;
      bus(1, `OFS_CONTROL, 32'h1);
      bus(1, `OFS_LEVEL, 32'h4);
      bus(1, `OFS_ENABLE, 32'h14);
      pins_n <= 16'hFFEB;
      cpu.exec(INSTR_COND, 0, 3'b110, 32'h0);
      base = cpu.n_acc;
      op(0, 32'h600);
      `CHK("level one", 5'h02, cpu.last.vector)
      op(0, 32'h604);
      `CHK("both masks", base + 1, cpu.n_acc)
   endtask
   task automatic finish_test;
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      t_reset_flags;
      t_conflict;
      t_mask_settle;
      t_moves;
      t_modes;
      finish_test;
   end
   initial begin
      #100000;
      err_count++;
      finish_test;
   end
endmodule
`default_nettype wire
